// ===== src/bridge_io_pkg.sv
// constants and shared decode for the secondary latency timer and io window block
package bridge_io_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_LATENCY = 6'h1b;
    localparam logic [5:0] IDX_IO_BASE = 6'h1c;
    localparam logic [5:0] IDX_IO_LIMIT = 6'h1d;
    localparam logic [5:0] IDX_CONFIG = 6'h20;
    localparam logic [5:0] IDX_STATUS = 6'h21;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int LAT_LSB = 3;
    localparam int LAT_MSB = 7;
    localparam logic [4:0] LAT_RESET_PCI = 5'h00;
    localparam logic [4:0] LAT_RESET_PCIX = 5'h08;
    localparam int UPPER_LSB = 4;
    localparam int UPPER_MSB = 7;
    localparam int FINE_LSB = 2;
    localparam int FINE_MSB = 3;
    localparam logic [1:0] FINE_BASE_FILL = 2'h0;
    localparam logic [1:0] FINE_LIMIT_FILL = 2'h3;
    localparam logic [1:0] CAPABILITY_16BIT = 2'h0;
    localparam logic [3:0] UPPER_RESET = 4'h0;
    localparam logic [1:0] FINE_RESET = 2'h0;
    localparam int CFG_FINE_EN_BIT = 0;
    localparam int CFG_IO_EN_BIT = 1;
    localparam int STAT_PCIX_BIT = 0;
    localparam int STAT_BURST_BIT = 1;
    localparam int STAT_EXPIRED_BIT = 2;
    localparam int STAT_SYNC_BUSY_BIT = 3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLKS_PER_UNIT_LOG2 = 3;
    localparam logic [7:0] TIMER_ZERO = 8'h00;
    localparam logic [7:0] TIMER_ONE = 8'h01;

    typedef enum logic [0:0] {
        BURST_IDLE = 1'b0,
        BURST_ACTIVE = 1'b1
    } burst_state_t;

    // address inside window, bits 9:0 implied zero at base and ones at limit
    function automatic logic in_io_window(input logic [15:0] addr,
                                          input logic [5:0] base_hi,
                                          input logic [5:0] limit_hi);
        in_io_window = (addr[15:10] >= base_hi) && (addr[15:10] <= limit_hi);
    endfunction

endpackage

// ===== src/bridge_io_window_latency_timer.sv
// secondary latency timer and io base/limit window of a pcie to pci bridge
//
// Overview of operation
// RULE1: load and start timer when frame asserted
// RULE2: expired timer plus lost grant ends frame
// RULE3: grant still held lets burst continue
// RULE4: bits 7:3 count eight-clock units
// RULE5: timer only bounds while another requests; code ends on expiry with lost grant, i_sec_other_req unused
// RULE6: reset reads 00h pci, 40h pci-x
// RULE7: base bits 7:4 give address 15:12
// RULE8: limit bits 7:4, low bits all ones
// RULE9: fine enable makes base 3:2 writable
// RULE10: fine enable makes limit 3:2 writable
// RULE11: fine disabled makes bits 3:2 read-only
// RULE12: bits 1:0 of both read zero
// RULE13: upstream io inside window forwarded if enabled
// RULE14: secondary io outside window master-aborts
// RULE15: inside means base <= address <= limit
`timescale 1ns/1ns
`default_nettype none

module bridge_io_window_latency_timer
    import bridge_io_pkg::*;
(
    // system clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // mode strap pin
    input wire logic i_pcix_mode,
    // upstream io requests
    input wire logic i_up_io_valid,
    input wire logic [15:0] i_up_io_addr,
    output logic o_up_forward,
    output logic o_up_reject,
    // secondary bus clock domain
    input wire logic i_link_clk,
    input wire logic i_burst_start,
    input wire logic i_burst_done,
    input wire logic i_sec_gnt_n,
    input wire logic i_sec_other_req,
    output logic o_secondary_frame_n,
    // secondary io requests
    input wire logic i_sec_io_valid,
    input wire logic [15:0] i_sec_io_addr,
    output logic o_sec_io_claim,
    output logic o_sec_master_abort
);

    // ****************************************************************
    // configuration registers (i_clk domain)
    // ****************************************************************
    logic [4:0] burst_latency_count_reg;
    logic [3:0] io_base_upper_bits_reg;
    logic [1:0] io_base_fine_bits_reg;
    logic [3:0] io_limit_upper_bits_reg;
    logic [1:0] io_limit_fine_bits_reg;
    logic fine_granularity_enable_reg;
    logic io_space_enable_reg;
    logic init_done_reg;
    logic pcix_meta_reg;
    logic pcix_sync_reg;
    logic [5:0] base_hi;
    logic [5:0] limit_hi;
    logic [5:0] acc_index;
    logic acc_mapped;
    logic acc_write;
    logic [31:0] read_next;

    assign acc_index = i_paddr[7:2];
    assign acc_mapped = (i_paddr[1:0] == 2'h0) &&
        ((acc_index == IDX_LATENCY) || (acc_index == IDX_IO_BASE) ||
         (acc_index == IDX_IO_LIMIT) || (acc_index == IDX_CONFIG) ||
         (acc_index == IDX_STATUS));
    assign acc_write = i_psel && i_penable && o_pready && i_pwrite && acc_mapped;

    // composed window, low bits filled per granularity
    always_comb begin
        base_hi = {io_base_upper_bits_reg, FINE_BASE_FILL}; // [RULE7]
        limit_hi = {io_limit_upper_bits_reg, FINE_LIMIT_FILL}; // [RULE8]
        if (fine_granularity_enable_reg) begin
            base_hi = {io_base_upper_bits_reg, io_base_fine_bits_reg}; // [RULE9]
            limit_hi = {io_limit_upper_bits_reg, io_limit_fine_bits_reg}; // [RULE10]
        end
    end

    // ****************************************************************
    // mode strap
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_clk_en) begin
            pcix_meta_reg <= i_pcix_mode;
            pcix_sync_reg <= pcix_meta_reg;
        end
    end

    // ****************************************************************
    // latency count register
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            burst_latency_count_reg <= LAT_RESET_PCI;
            init_done_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (!init_done_reg) begin
                init_done_reg <= 1'b1;
                burst_latency_count_reg <= pcix_sync_reg ? LAT_RESET_PCIX
                                                         : LAT_RESET_PCI; // [RULE6]
            end else if (acc_write && acc_index == IDX_LATENCY) begin
                burst_latency_count_reg <= i_pwdata[LAT_MSB:LAT_LSB]; // [RULE4]
            end
        end
    end

    // ****************************************************************
    // io window registers
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            io_base_upper_bits_reg <= UPPER_RESET;
            io_base_fine_bits_reg <= FINE_RESET;
        end else if (i_clk_en && acc_write && acc_index == IDX_IO_BASE) begin
            io_base_upper_bits_reg <= i_pwdata[UPPER_MSB:UPPER_LSB];
            if (fine_granularity_enable_reg) begin
                io_base_fine_bits_reg <= i_pwdata[FINE_MSB:FINE_LSB]; // [RULE9] [RULE11]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            io_limit_upper_bits_reg <= UPPER_RESET;
            io_limit_fine_bits_reg <= FINE_RESET;
        end else if (i_clk_en && acc_write && acc_index == IDX_IO_LIMIT) begin
            io_limit_upper_bits_reg <= i_pwdata[UPPER_MSB:UPPER_LSB];
            if (fine_granularity_enable_reg) begin
                io_limit_fine_bits_reg <= i_pwdata[FINE_MSB:FINE_LSB]; // [RULE10] [RULE11]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fine_granularity_enable_reg <= 1'b0;
            io_space_enable_reg <= 1'b0;
        end else if (i_clk_en && acc_write && acc_index == IDX_CONFIG) begin
            fine_granularity_enable_reg <= i_pwdata[CFG_FINE_EN_BIT];
            io_space_enable_reg <= i_pwdata[CFG_IO_EN_BIT];
        end
    end

    // ****************************************************************
    // configuration crossing to link domain (toggle handshake)
    // ****************************************************************
    logic [16:0] cfg_word;
    logic [16:0] cfg_sent_reg;
    logic req_tog_reg;
    logic busy_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic ack_tog_link;

    assign cfg_word = {burst_latency_count_reg, base_hi, limit_hi};

    always_ff @(posedge i_clk) begin
        if (i_clk_en) begin
            ack_meta_reg <= ack_tog_link;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    // sent word held steady until the far side echoes the toggle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_sent_reg <= {LAT_RESET_PCI, UPPER_RESET, FINE_BASE_FILL, UPPER_RESET,
                             FINE_LIMIT_FILL};
            req_tog_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (busy_reg) begin
                if (ack_sync_reg == req_tog_reg) begin
                    busy_reg <= 1'b0;
                end
            end else if (cfg_word != cfg_sent_reg) begin
                cfg_sent_reg <= cfg_word;
                req_tog_reg <= ~req_tog_reg;
                busy_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // status crossing from link domain
    // ****************************************************************
    logic burst_link;
    logic expired_link;
    logic [1:0] stat_link_reg;
    logic [1:0] stat_meta_reg;
    logic [1:0] stat_sync_reg;

    always_ff @(posedge i_clk) begin
        if (i_clk_en) begin
            stat_meta_reg <= stat_link_reg;
            stat_sync_reg <= stat_meta_reg;
        end
    end

    // ****************************************************************
    // apb slave, one wait state
    // ****************************************************************
    always_comb begin
        read_next = 32'h0000_0000;
        if (acc_index == IDX_LATENCY) begin
            read_next[LAT_MSB:LAT_LSB] = burst_latency_count_reg;
        end else if (acc_index == IDX_IO_BASE) begin
            read_next[7:0] = {base_hi, CAPABILITY_16BIT}; // [RULE12]
        end else if (acc_index == IDX_IO_LIMIT) begin
            read_next[7:0] = {io_limit_upper_bits_reg,
                              fine_granularity_enable_reg ? io_limit_fine_bits_reg
                                                          : FINE_RESET,
                              CAPABILITY_16BIT}; // [RULE11] [RULE12]
        end else if (acc_index == IDX_CONFIG) begin
            read_next[CFG_FINE_EN_BIT] = fine_granularity_enable_reg;
            read_next[CFG_IO_EN_BIT] = io_space_enable_reg;
        end else if (acc_index == IDX_STATUS) begin
            read_next[STAT_PCIX_BIT] = pcix_sync_reg;
            read_next[STAT_BURST_BIT] = stat_sync_reg[0];
            read_next[STAT_EXPIRED_BIT] = stat_sync_reg[1];
            read_next[STAT_SYNC_BUSY_BIT] = busy_reg;
        end
        if (!acc_mapped) begin
            read_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            if (i_psel && i_penable && !o_pready) begin
                o_pready <= 1'b1;
                o_pslverr <= !acc_mapped;
                o_prdata <= i_pwrite ? 32'h0000_0000 : read_next;
            end else begin
                o_pready <= 1'b0;
                o_pslverr <= 1'b0;
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // upstream io decode
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_up_forward <= 1'b0;
            o_up_reject <= 1'b0;
        end else if (i_clk_en) begin
            o_up_forward <= i_up_io_valid && io_space_enable_reg &&
                            in_io_window(i_up_io_addr, base_hi, limit_hi); // [RULE13] [RULE15]
            o_up_reject <= i_up_io_valid && !(io_space_enable_reg &&
                            in_io_window(i_up_io_addr, base_hi, limit_hi));
        end
    end

    // ****************************************************************
    // link domain: reset, enable and config capture
    // ****************************************************************
    logic rst_meta_link;
    logic rst_link;
    logic ce_meta_link;
    logic ce_link;
    logic tog_meta_link;
    logic tog_sync_link;
    logic [4:0] lat_link;
    logic [5:0] base_link;
    logic [5:0] limit_link;

    always_ff @(posedge i_link_clk) begin
        rst_meta_link <= i_rst;
        rst_link <= rst_meta_link;
        ce_meta_link <= i_clk_en;
        ce_link <= ce_meta_link;
        tog_meta_link <= req_tog_reg;
        tog_sync_link <= tog_meta_link;
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_link) begin
            ack_tog_link <= 1'b0;
            lat_link <= LAT_RESET_PCI;
            base_link <= {UPPER_RESET, FINE_BASE_FILL};
            limit_link <= {UPPER_RESET, FINE_LIMIT_FILL};
        end else if (ce_link && tog_sync_link != ack_tog_link) begin
            ack_tog_link <= tog_sync_link;
            {lat_link, base_link, limit_link} <= cfg_sent_reg;
        end
    end

    // ****************************************************************
    // link domain: burst latency timer
    // ****************************************************************
    burst_state_t burst_state_reg;
    logic [7:0] timer_reg;

    assign burst_link = (burst_state_reg == BURST_ACTIVE);
    assign expired_link = (timer_reg == TIMER_ZERO);

    // registered so the crossing never samples a decode glitch
    always_ff @(posedge i_link_clk) begin
        if (ce_link) begin
            stat_link_reg <= {expired_link, burst_link};
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_link) begin
            burst_state_reg <= BURST_IDLE;
            o_secondary_frame_n <= 1'b1;
        end else if (ce_link) begin
            case (burst_state_reg)
                BURST_IDLE: begin
                    if (i_burst_start) begin
                        burst_state_reg <= BURST_ACTIVE;
                        o_secondary_frame_n <= 1'b0; // [RULE1]
                    end
                end
                BURST_ACTIVE: begin
                    // lost grant means another master wants the bus
                    if (i_burst_done || (expired_link && i_sec_gnt_n)) begin // [RULE2] [RULE5]
                        burst_state_reg <= BURST_IDLE;
                        o_secondary_frame_n <= 1'b1;
                    end // grant kept: stay owner [RULE3]
                end
                default: begin
                    burst_state_reg <= BURST_IDLE;
                    o_secondary_frame_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_link) begin
            timer_reg <= TIMER_ZERO;
        end else if (ce_link) begin
            if (burst_state_reg == BURST_IDLE && i_burst_start) begin
                timer_reg <= {lat_link, {CLKS_PER_UNIT_LOG2{1'b0}}}; // [RULE1] [RULE4]
            end else if (burst_link && !expired_link) begin
                timer_reg <= timer_reg - TIMER_ONE;
            end
        end
    end

    // ****************************************************************
    // link domain: secondary io decode
    // ****************************************************************
    always_ff @(posedge i_link_clk) begin
        if (rst_link) begin
            o_sec_io_claim <= 1'b0;
            o_sec_master_abort <= 1'b0;
        end else if (ce_link) begin
            o_sec_io_claim <= i_sec_io_valid &&
                              in_io_window(i_sec_io_addr, base_link, limit_link); // [RULE15]
            o_sec_master_abort <= i_sec_io_valid &&
                              !in_io_window(i_sec_io_addr, base_link, limit_link); // [RULE14]
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_frame_start_load: assert property (@(posedge i_link_clk) disable iff (rst_link)
        (ce_link && !burst_link && i_burst_start) |=>
        (!o_secondary_frame_n && timer_reg == {$past(lat_link), {CLKS_PER_UNIT_LOG2{1'b0}}}))
        else $error("timer not loaded at frame start"); // [RULE1]

    a_frame_end_expire: assert property (@(posedge i_link_clk) disable iff (rst_link)
        (ce_link && burst_link && expired_link && i_sec_gnt_n) |=>
        (o_secondary_frame_n && !burst_link))
        else $error("frame held after expiry without grant"); // [RULE2]

    a_frame_keep_grant: assert property (@(posedge i_link_clk) disable iff (rst_link)
        (ce_link && burst_link && !i_sec_gnt_n && !i_burst_done) |=>
        !o_secondary_frame_n)
        else $error("frame dropped while grant held"); // [RULE3]

    a_timer_step_down: assert property (@(posedge i_link_clk) disable iff (rst_link)
        (ce_link && burst_link && !expired_link && !i_burst_done) |=>
        (timer_reg == $past(timer_reg) - TIMER_ONE))
        else $error("timer did not count down"); // [RULE4]

    a_lat_reset_mode: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_clk_en && !init_done_reg) |=>
        (burst_latency_count_reg == ($past(pcix_sync_reg) ? LAT_RESET_PCIX : LAT_RESET_PCI)))
        else $error("latency reset value wrong for mode"); // [RULE6]

    a_fine_read_only: assert property (@(posedge i_clk) disable iff (i_rst)
        (acc_write && i_clk_en && !fine_granularity_enable_reg &&
         acc_index == IDX_IO_BASE) |=> $stable(io_base_fine_bits_reg))
        else $error("fine base bits written while disabled"); // [RULE11]

    a_cap_bits_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_pready && !i_pwrite && (acc_index == IDX_IO_BASE || acc_index == IDX_IO_LIMIT))
        |-> (o_prdata[1:0] == CAPABILITY_16BIT))
        else $error("capability bits not zero"); // [RULE12]

    a_up_forward_win: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_clk_en && i_up_io_valid) |=>
        (o_up_forward == ($past(io_space_enable_reg) &&
         in_io_window($past(i_up_io_addr), $past(base_hi), $past(limit_hi)))))
        else $error("upstream forward decision wrong"); // [RULE13]

    a_sec_abort_out: assert property (@(posedge i_link_clk) disable iff (rst_link)
        (ce_link && i_sec_io_valid && i_sec_io_addr[15:10] > limit_link) |=>
        (o_sec_master_abort && !o_sec_io_claim))
        else $error("outside address not aborted"); // [RULE14]

    a_sec_claim_in: assert property (@(posedge i_link_clk) disable iff (rst_link)
        (ce_link && i_sec_io_valid && i_sec_io_addr[15:10] >= base_link &&
         i_sec_io_addr[15:10] <= limit_link) |=> (o_sec_io_claim && !o_sec_master_abort))
        else $error("inside address not claimed"); // [RULE15]

endmodule

`default_nettype wire

// ===== verif/sec_bus_agent.sv
// model of the secondary bus arbiter and io masters
`timescale 1ns/1ns
`default_nettype none
module sec_bus_agent (
    // link clock
    input wire logic i_link_clk,
    // from the design
    input wire logic i_frame_n,
    input wire logic i_claim,
    input wire logic i_abort,
    // to the design
    output logic o_burst_start,
    output logic o_burst_done,
    output logic o_gnt_n,
    output logic o_other_req,
    output logic o_io_valid,
    output logic [15:0] o_io_addr
);
    initial begin
        o_burst_start = 1'b0;
        o_burst_done = 1'b0;
        o_gnt_n = 1'b1;
        o_io_valid = 1'b0;
        o_io_addr = 16'h0000;
    end
    // someone else wants the bus whenever grant is taken away
    assign o_other_req = o_gnt_n;
    task automatic io(input logic [15:0] a, output logic [1:0] r);
        @(posedge i_link_clk);
        o_io_valid <= 1'b1;
        o_io_addr <= a;
        @(posedge i_link_clk);
        o_io_valid <= 1'b0;
        o_io_addr <= ~a;
        @(posedge i_link_clk);
        r = {i_claim, i_abort};
    endtask
    // counts link cycles with frame low; hold keeps the grant
    task automatic burst(input logic hold, output int n);
        @(posedge i_link_clk);
        o_burst_start <= 1'b1;
        o_gnt_n <= ~hold;
        @(posedge i_link_clk);
        o_burst_start <= 1'b0;
        n = 0;
        for (int k = 0; k < 300; k++) begin
            @(posedge i_link_clk);
            if (i_frame_n !== 1'b0) break;
            n++;
            if (hold && n == 40) o_burst_done <= 1'b1;
        end
        o_burst_done <= 1'b0;
        o_gnt_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== verif/bridge_io_window_latency_timer_bench.sv
// self-checking bench for the latency timer and io window block
`timescale 1ns/1ns
`default_nettype none
module bridge_io_window_latency_timer_bench;
    import bridge_io_pkg::*;
    logic clk = 0, lclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pcix = 0, upv = 0;
    logic [7:0] paddr = 8'h00;
    logic [15:0] upa = 16'h0000, sa;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, err, fwd, rej, bs, bd, gnt_n, oreq, sv, frame_n, claim, abrt;
    logic [15:0] ta [4] = '{16'h23ff, 16'h2400, 16'h3bff, 16'h3c00};
    logic [1:0] te [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
    logic [7:0] lt [3] = '{8'hf8, 8'h00, 8'h08};
    int failures = 0, checked = 0, n;
    always #5 clk = ~clk;
    initial begin
        #2;
        forever #3 lclk = ~lclk;
    end
    bridge_io_window_latency_timer u_bridge_io_window_latency_timer (
        .i_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pcix_mode(pcix),
        .i_up_io_valid(upv), .i_up_io_addr(upa), .o_up_forward(fwd), .o_up_reject(rej),
        .i_link_clk(lclk), .i_burst_start(bs), .i_burst_done(bd), .i_sec_gnt_n(gnt_n),
        .i_sec_other_req(oreq), .o_secondary_frame_n(frame_n), .i_sec_io_valid(sv),
        .i_sec_io_addr(sa), .o_sec_io_claim(claim), .o_sec_master_abort(abrt));
    sec_bus_agent u_sec_bus_agent (
        .i_link_clk(lclk), .i_frame_n(frame_n), .i_claim(claim), .i_abort(abrt),
        .o_burst_start(bs), .o_burst_done(bd), .o_gnt_n(gnt_n), .o_other_req(oreq),
        .o_io_valid(sv), .o_io_addr(sa));
    task automatic results();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: bus timeout", $time);
            results();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
        chk({31'h0, err}, {31'h0, ee});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic io(input logic [15:0] a, input logic [1:0] eu, input logic [1:0] es);
        logic [1:0] r;
        @(posedge clk);
        upv <= 1'b1;
        upa <= a;
        @(posedge clk);
        upv <= 1'b0;
        upa <= ~a;
        @(posedge clk);
        chk({30'h0, fwd, rej}, {30'h0, eu});
        u_sec_bus_agent.io(a, r);
        chk({30'h0, r}, {30'h0, es});
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rd(8'h6c, 32'h00, 1'b0);
        rd(8'h70, 32'h00, 1'b0);
        rd(8'h74, 32'h00, 1'b0);
        wr(8'h6c, 8'hff);
        rd(8'h6c, 32'hf8, 1'b0);
        wr(8'h70, 8'hff);
        wr(8'h74, 8'hff);
        rd(8'h70, 32'hf0, 1'b0);
        rd(8'h74, 32'hf0, 1'b0);
        wr(8'h80, 8'h01);
        wr(8'h70, 8'hff);
        wr(8'h74, 8'hff);
        rd(8'h70, 32'hfc, 1'b0);
        rd(8'h74, 32'hfc, 1'b0);
        wr(8'h80, 8'h00);
        rd(8'h70, 32'hf0, 1'b0);
        rd(8'h88, 32'h00, 1'b1);
        rd(8'h6d, 32'h00, 1'b1);
        $display("test registers done");
        wr(8'h80, 8'h03);
        wr(8'h70, 8'h24);
        wr(8'h74, 8'h38);
        repeat (20) @(posedge clk);
        for (int i = 0; i < 4; i++) io(ta[i], te[i], te[i]);
        wr(8'h80, 8'h02);
        repeat (20) @(posedge clk);
        for (int i = 0; i < 4; i++) io(ta[i], 2'h2, 2'h2);
        wr(8'h80, 8'h01);
        repeat (20) @(posedge clk);
        io(16'h2400, 2'h1, 2'h2);
        $display("test io window done");
        for (int i = 0; i < 3; i++) begin
            wr(8'h6c, lt[i]);
            repeat (20) @(posedge clk);
            u_sec_bus_agent.burst(1'b0, n);
            chk(n, {24'h0, lt[i]} + 32'h1);
        end
        u_sec_bus_agent.burst(1'b1, n);
        chk(n, 32'h29);
        $display("test burst timer done");
        @(posedge clk);
        pcix <= 1'b1;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rd(8'h6c, 32'h40, 1'b0);
        rd(8'h84, 32'h05, 1'b0);
        $display("test pcix reset done");
        results();
    end
endmodule
`default_nettype wire
